// >>> pria_cfg.svh
`ifndef PRIA_CFG_SVH
`define PRIA_CFG_SVH
`define PRIA_OFS_SELECT      12'h000
`define PRIA_OFS_DATA        12'h004
`define PRIA_OFS_RX_LANE     12'h008
`define PRIA_SLOT_LSB        0
`define PRIA_SLOT_MSB        6
`define PRIA_TSEL_LSB        8
`define PRIA_TSEL_MSB        9
`define PRIA_DIR_BIT         14
`define PRIA_BUSY_BIT        15
`define PRIA_SELECT_RESET    16'h0000
`define PRIA_DATA_RESET      16'h0000
`define PRIA_SELECT_WMASK    16'h437f
`define PRIA_ACCESS_NS       10
`define PRIA_CLK_NS          5
`define PRIA_ACCESS_CYCLES   ((`PRIA_ACCESS_NS + `PRIA_CLK_NS - 1) / `PRIA_CLK_NS)
`endif

// >>> pria_pkg.sv
package pria_pkg;
    typedef enum logic [1:0] {
        PRIA_TBL_DS0 = 2'h0,
        PRIA_TBL_RX  = 2'h1,
        PRIA_TBL_TX  = 2'h2,
        PRIA_TBL_BAD = 2'h3
    } pria_tbl_type;

    typedef enum logic [2:0] {
        PRIA_IDLE = 3'h1,
        PRIA_WAIT = 3'h2,
        PRIA_DONE = 3'h4
    } pria_state_type;

    typedef struct packed {
        logic         busy;
        logic         dir;
        logic [3:0]   unused;
        pria_tbl_type tsel;
        logic         spare;
        logic [6:0]   slot;
    } pria_select_type;

    typedef struct packed {
        logic [7:0] tx_byte;
        logic [7:0] rx_byte;
    } pria_ds0_type;
endpackage

// >>> pria_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pria_cfg.svh"

module pria_top import pria_pkg::*; #(
    parameter int DEPTH = 128
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Layer one datapath lanes
    input  wire logic        rx_byte_valid,
    input  wire logic [6:0]  rx_byte_slot,
    input  wire logic [7:0]  rx_byte_data,
    input  wire logic        tx_byte_valid,
    input  wire logic [6:0]  tx_byte_slot,
    input  wire logic [7:0]  tx_byte_data,
    // Config lookup for the active slot, plus busy status
    input  wire logic [6:0]  cfg_slot,
    output logic      [15:0] rx_cfg_word,
    output logic      [15:0] tx_cfg_word,
    output logic             busy_out
);
    localparam int ACC_CYC = `PRIA_ACCESS_CYCLES;

    pria_select_type    select_q;
    logic [15:0]        data_q;
    pria_state_type     state_q, state_d;
    logic [2:0]         cnt_q;
    logic [31:0]        prdata_q;
    logic               pready_q, pslverr_q;
    logic [15:0]        rxcfg_q, txcfg_q;
    pria_ds0_type       ds0_mem [DEPTH];
    logic [15:0]        rxc_mem [DEPTH];
    logic [15:0]        txc_mem [DEPTH];

    // Bus decode
    wire        acc      = psel && penable && !pready_q;
    wire        hit_sel  = paddr == `PRIA_OFS_SELECT;
    wire        hit_dat  = paddr == `PRIA_OFS_DATA;
    wire        hit_rxl  = paddr == `PRIA_OFS_RX_LANE;
    wire        mapped   = hit_sel || hit_dat || hit_rxl;
    wire        wr_sel   = acc && pwrite && hit_sel && !select_q.busy;
    wire        wr_dat   = acc && pwrite && hit_dat && !select_q.busy;
    wire [15:0] sel_wval = pwdata[15:0] & `PRIA_SELECT_WMASK;
    wire        idle     = state_q == PRIA_IDLE;
    wire        finish   = state_q == PRIA_WAIT && cnt_q == 3'(ACC_CYC - 1);
    wire [6:0]  slot     = select_q.slot;
    wire        do_write = finish && !select_q.dir;
    wire        do_read  = finish && select_q.dir;
    wire [15:0] rd_word  = select_q.tsel == PRIA_TBL_DS0 ? ds0_mem[slot] :
                           select_q.tsel == PRIA_TBL_RX  ? rxc_mem[slot] :
                           select_q.tsel == PRIA_TBL_TX  ? txc_mem[slot] : data_q;
    wire [31:0] rd_mux   = hit_sel ? {16'h0000, select_q} :
                           hit_dat ? {16'h0000, data_q} :
                           hit_rxl ? {16'h0000, rxcfg_q} : 32'h0000_0000;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PRIA_IDLE: if (wr_sel) state_d = PRIA_WAIT;
            PRIA_WAIT: if (finish) state_d = PRIA_DONE;
            PRIA_DONE: state_d = PRIA_IDLE;
            default:   state_d = PRIA_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= PRIA_IDLE;
            cnt_q   <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_q == PRIA_WAIT && !finish) ? cnt_q + 3'h1 : 3'h0;
        end
    end

    // Select register, busy owned by hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_q <= pria_select_type'(`PRIA_SELECT_RESET);
        end else if (wr_sel && idle) begin
            select_q      <= pria_select_type'(sel_wval);
            select_q.busy <= 1'b1;
        end else if (state_q == PRIA_DONE) begin
            select_q.busy <= 1'b0;
        end
    end

    // Data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= `PRIA_DATA_RESET;
        end else if (do_read) begin
            data_q <= rd_word;
        end else if (wr_dat) begin
            data_q <= pwdata[15:0];
        end
    end

    // Port RAM tables; host write wins over lane update
    always_ff @(posedge pclk) begin
        if (rx_byte_valid) begin
            ds0_mem[rx_byte_slot].rx_byte <= rx_byte_data;
        end
        if (tx_byte_valid) begin
            ds0_mem[tx_byte_slot].tx_byte <= tx_byte_data;
        end
        if (do_write && select_q.tsel == PRIA_TBL_DS0) begin
            ds0_mem[slot] <= pria_ds0_type'(data_q);
        end
        if (do_write && select_q.tsel == PRIA_TBL_RX) begin
            rxc_mem[slot] <= data_q;
        end
        if (do_write && select_q.tsel == PRIA_TBL_TX) begin
            txc_mem[slot] <= data_q;
        end
        rx_cfg_word <= rxc_mem[cfg_slot];
        tx_cfg_word <= txc_mem[cfg_slot];
    end

    // Snapshot of slot 0 rx config
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxcfg_q <= 16'h0000;
        end else begin
            rxcfg_q <= rxc_mem[7'h00];
        end
    end

    // APB response, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc && !mapped;
            prdata_q  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= state_d != PRIA_IDLE;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    property p_busy_set;
        @(posedge pclk) disable iff (!presetn)
        wr_sel && idle |=> select_q.busy;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set");

    property p_busy_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(select_q.busy) |-> ##[1:8] !select_q.busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy stuck");

    property p_read_data;
        @(posedge pclk) disable iff (!presetn)
        do_read |=> data_q == $past(rd_word);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data lost");

    property p_data_before_idle;
        @(posedge pclk) disable iff (!presetn)
        $fell(select_q.busy) && select_q.dir && select_q.tsel == PRIA_TBL_RX
            |-> data_q == rxc_mem[slot];
    endproperty
    a_data_before_idle: assert property (p_data_before_idle) else $error("busy early");

    property p_write_tbl;
        @(posedge pclk) disable iff (!presetn)
        do_write && select_q.tsel == PRIA_TBL_TX |=> txc_mem[$past(slot)] == $past(data_q);
    endproperty
    a_write_tbl: assert property (p_write_tbl) else $error("write lost");

    property p_bad_sel;
        @(posedge pclk) disable iff (!presetn)
        do_write && select_q.tsel == PRIA_TBL_BAD |=> rxc_mem[$past(slot)] == $past(rxc_mem[slot]);
    endproperty
    a_bad_sel: assert property (p_bad_sel) else $error("illegal table written");

    property p_spare_zero;
        @(posedge pclk) disable iff (!presetn)
        !select_q.spare && select_q.unused == 4'h0;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare bit set");

    property p_ds0_rx;
        @(posedge pclk) disable iff (!presetn)
        rx_byte_valid && !do_write |=> ds0_mem[$past(rx_byte_slot)].rx_byte == $past(rx_byte_data);
    endproperty
    a_ds0_rx: assert property (p_ds0_rx) else $error("rx byte lost");

    property p_busy_wait;
        @(posedge pclk) disable iff (!presetn)
        wr_sel && idle |=> select_q.busy [*2];
    endproperty
    a_busy_wait: assert property (p_busy_wait) else $error("busy too short");

    property p_busy_state;
        @(posedge pclk) disable iff (!presetn)
        select_q.busy == !idle;
    endproperty
    a_busy_state: assert property (p_busy_state) else $error("busy out of step");

    property p_busy_mirror;
        @(posedge pclk) disable iff (!presetn)
        busy_out == select_q.busy;
    endproperty
    a_busy_mirror: assert property (p_busy_mirror) else $error("busy pin differs");

    property p_sel_hold;
        @(posedge pclk) disable iff (!presetn)
        select_q.busy |=> select_q.slot == $past(select_q.slot);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved while busy");

    property p_data_hold;
        @(posedge pclk) disable iff (!presetn)
        select_q.busy && !do_read |=> data_q == $past(data_q);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved while busy");

    property p_wr_data;
        @(posedge pclk) disable iff (!presetn)
        wr_dat |=> data_q == $past(pwdata[15:0]);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("data write lost");

    property p_write_rx;
        @(posedge pclk) disable iff (!presetn)
        do_write && select_q.tsel == PRIA_TBL_RX |=> rxc_mem[$past(slot)] == $past(data_q);
    endproperty
    a_write_rx: assert property (p_write_rx) else $error("rx config write lost");

    property p_write_ds0;
        @(posedge pclk) disable iff (!presetn)
        do_write && select_q.tsel == PRIA_TBL_DS0
            |=> ds0_mem[$past(slot)] == pria_ds0_type'($past(data_q));
    endproperty
    a_write_ds0: assert property (p_write_ds0) else $error("ds0 write lost");

    property p_ds0_tx;
        @(posedge pclk) disable iff (!presetn)
        tx_byte_valid && !do_write |=> ds0_mem[$past(tx_byte_slot)].tx_byte == $past(tx_byte_data);
    endproperty
    a_ds0_tx: assert property (p_ds0_tx) else $error("tx byte lost");

    property p_fetch_done;
        @(posedge pclk) disable iff (!presetn)
        wr_sel && idle && pwdata[`PRIA_DIR_BIT] |-> ##[1:8] do_read;
    endproperty
    a_fetch_done: assert property (p_fetch_done) else $error("fetch never ran");

    property p_write_done;
        @(posedge pclk) disable iff (!presetn)
        wr_sel && idle && !pwdata[`PRIA_DIR_BIT] |-> ##[1:8] do_write;
    endproperty
    a_write_done: assert property (p_write_done) else $error("store never ran");

    property p_busy_until_data;
        @(posedge pclk) disable iff (!presetn)
        do_read |-> select_q.busy;
    endproperty
    a_busy_until_data: assert property (p_busy_until_data) else $error("busy low in fetch");

    property p_reset_zero;
        @(posedge pclk)
        !presetn |-> select_q == pria_select_type'(`PRIA_SELECT_RESET) && data_q == `PRIA_DATA_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

    property p_tsel_illegal;
        @(posedge pclk) disable iff (!presetn)
        do_write && select_q.tsel == PRIA_TBL_BAD |=> txc_mem[$past(slot)] == $past(txc_mem[slot]);
    endproperty
    a_tsel_illegal: assert property (p_tsel_illegal) else $error("illegal table stored");

    property p_bad_read;
        @(posedge pclk) disable iff (!presetn)
        do_read && select_q.tsel == PRIA_TBL_BAD |=> data_q == $past(data_q);
    endproperty
    a_bad_read: assert property (p_bad_read) else $error("illegal fetch changed data");

    property p_slot_load;
        @(posedge pclk) disable iff (!presetn)
        wr_sel && idle |=> select_q.slot == $past(pwdata[`PRIA_SLOT_MSB:`PRIA_SLOT_LSB]);
    endproperty
    a_slot_load: assert property (p_slot_load) else $error("slot id not loaded");

    property p_tsel_load;
        @(posedge pclk) disable iff (!presetn)
        wr_sel && idle |=> select_q.tsel == $past(pwdata[`PRIA_TSEL_MSB:`PRIA_TSEL_LSB]);
    endproperty
    a_tsel_load: assert property (p_tsel_load) else $error("table select not loaded");
endmodule // pria_top

`default_nettype wire

// >>> tb_port_ram_indirect_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "pria_cfg.svh"
module tb_port_ram_indirect_access import pria_pkg::*; ;
    logic        pclk          = 1'b0;
    logic        presetn       = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [11:0] paddr         = 12'h000;
    logic [31:0] pwdata        = 32'h0;
    logic        rx_byte_valid = 1'b0;
    logic [6:0]  rx_byte_slot  = 7'h00;
    logic [7:0]  rx_byte_data  = 8'h00;
    logic        tx_byte_valid = 1'b0;
    logic [6:0]  tx_byte_slot  = 7'h00;
    logic [7:0]  tx_byte_data  = 8'h00;
    logic [6:0]  cfg_slot      = 7'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] rx_cfg_word;
    logic [15:0] tx_cfg_word;
    logic        busy_out;
    logic [31:0] rd_q;
    logic        err_q;
    logic        busy_seen;
    logic [6:0]  slots [5]     = '{7'h00, 7'h17, 7'h1f, 7'h3f, 7'h7f};
    int          n_mismatch    = 0;
    int          samples_checked = 0;

    always #2.5 pclk = ~pclk;

    pria_top #(.DEPTH(128)) pria_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_byte_valid(rx_byte_valid), .rx_byte_slot(rx_byte_slot), .rx_byte_data(rx_byte_data),
        .tx_byte_valid(tx_byte_valid), .tx_byte_slot(tx_byte_slot), .tx_byte_data(tx_byte_data),
        .cfg_slot(cfg_slot), .rx_cfg_word(rx_cfg_word), .tx_cfg_word(tx_cfg_word),
        .busy_out(busy_out)
    );

    task automatic summarize;
        $display("Counts: checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, access until pready, then release
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rd_q      = prdata;
        err_q     = pslverr;
        busy_seen = busy_out;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Issue a command with junk in the spare and busy bits, then poll busy
    task automatic cmd(input logic dir, input logic [1:0] tbl, input logic [6:0] slot);
        int n;
        xfer(1'b1, `PRIA_OFS_SELECT, {16'hffff, 1'b1, dir, 4'hf, tbl, 1'b1, slot});
        chk({31'h0, busy_seen}, 32'h1);
        n = 0;
        do begin
            xfer(1'b0, `PRIA_OFS_SELECT, 32'h0);
            n++;
        end while (rd_q[`PRIA_BUSY_BIT] !== 1'b0 && n < 10);
        chk(rd_q, {16'h0, 1'b0, dir, 4'h0, tbl, 1'b0, slot});
    endtask

    task automatic put(input logic [1:0] tbl, input logic [6:0] slot, input logic [15:0] v);
        xfer(1'b1, `PRIA_OFS_DATA, {16'hffff, v});
        cmd(1'b0, tbl, slot);
    endtask

    task automatic get(input logic [1:0] tbl, input logic [6:0] slot, input logic [15:0] v);
        cmd(1'b1, tbl, slot);
        xfer(1'b0, `PRIA_OFS_DATA, 32'h0);
        chk(rd_q, {16'h0, v});
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `PRIA_OFS_SELECT, 32'h0);
        chk(rd_q, {16'h0, `PRIA_SELECT_RESET});
        xfer(1'b0, `PRIA_OFS_DATA, 32'h0);
        chk(rd_q, {16'h0, `PRIA_DATA_RESET});
        xfer(1'b0, 12'hffc, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        xfer(1'b1, `PRIA_OFS_DATA, 32'hffffffff);
        xfer(1'b0, `PRIA_OFS_DATA, 32'h0);
        chk(rd_q, 32'h0000ffff);
        $display("test reset_and_width done");
        for (int t = 1; t < 3; t++)
            for (int i = 0; i < 5; i++) put(t[1:0], slots[i], {t[7:0], slots[i], t[0]});
        for (int t = 1; t < 3; t++)
            for (int i = 0; i < 5; i++) get(t[1:0], slots[i], {t[7:0], slots[i], t[0]});
        $display("test config_tables done");
        put(PRIA_TBL_BAD, 7'h17, 16'h1234);
        get(PRIA_TBL_RX, 7'h17, {8'h01, 7'h17, 1'b1});
        get(PRIA_TBL_TX, 7'h17, {8'h02, 7'h17, 1'b0});
        xfer(1'b1, `PRIA_OFS_DATA, 32'h0000beef);
        cmd(1'b1, PRIA_TBL_BAD, 7'h17);
        xfer(1'b0, `PRIA_OFS_DATA, 32'h0);
        chk(rd_q, 32'h0000beef);
        $display("test illegal_table done");
        put(PRIA_TBL_TX, 7'h7f, 16'hcb7e);
        put(PRIA_TBL_RX, 7'h00, 16'hd5ff);
        cfg_slot <= 7'h7f;
        repeat (2) @(posedge pclk);
        chk({16'h0, tx_cfg_word}, 32'h0000cb7e);
        cfg_slot <= 7'h00;
        repeat (2) @(posedge pclk);
        chk({16'h0, rx_cfg_word}, 32'h0000d5ff);
        xfer(1'b0, `PRIA_OFS_RX_LANE, 32'h0);
        chk(rd_q, 32'h0000d5ff);
        $display("test config_fields done");
        for (int k = 0; k < 2; k++) begin
            rx_byte_valid <= 1'b1;
            tx_byte_valid <= 1'b1;
            rx_byte_slot  <= k ? 7'h7f : 7'h05;
            tx_byte_slot  <= k ? 7'h7f : 7'h05;
            rx_byte_data  <= k ? 8'h81 : 8'h3c;
            tx_byte_data  <= k ? 8'h7e : 8'ha5;
            @(posedge pclk);
        end
        rx_byte_valid <= 1'b0;
        tx_byte_valid <= 1'b0;
        @(posedge pclk);
        get(PRIA_TBL_DS0, 7'h05, 16'ha53c);
        get(PRIA_TBL_DS0, 7'h7f, 16'h7e81);
        $display("test ds0_lanes done");
        summarize();
    end

    initial begin
        #(`PRIA_CLK_NS * 20000);
        n_mismatch++;
        summarize();
    end
endmodule // tb_port_ram_indirect_access
`default_nettype wire
